// *** prp_port2_reset.sv ***
// shared reset pin and port 2 pin logic
// Operation
// - low on the shared pin as reset resets all ports and peripherals
// - after external reset release the processor fetches from address zero
// - pin is a reset during power-on, otherwise only when configuration selects it
// - pin sampled in power-on sequence to choose in-system programming mode
// - otherwise the pin is only input port1 bit 5, never driven
// - port 2 has five bits, 0 to 3 and 5, each configurable
// - during reset port 2 is input only with pull-up off
// - each port 2 pin configured independently and behaves per its mode
// - bit 2 as MOSI drives in master role, input in slave role
// - bit 3 as MISO input in master role, drives in slave role
// - bit 5 as serial clock drives in master role, input in slave role
`timescale 1ns/1ps
module prp_port2_reset #(
    parameter int POR_CYCLES = 8
) (
    // clock and reset
    input  wire logic                     sys_clk,
    input  wire logic                     rst_n,
    // shared reset pin
    input  wire logic                     rst_pin_i,
    input  wire logic                     user_config_byte_one_rst_en,
    output      logic                     port1_bit5_input,
    output      logic                     rst_pin_oe,
    output      logic                     in_system_programming_mode,
    output      logic                     periph_rst_n,
    output      logic [15:0]              fetch_addr,
    output      logic                     fetch_addr_load,
    // port 2 configuration and data
    input  wire logic [9:0]               p2_mode_i,
    input  wire logic [4:0]               p2_latch_wr_data,
    input  wire logic                     p2_latch_wr,
    input  wire logic                     spi_en,
    input  wire logic                     spi_master,
    input  wire logic                     spi_mosi_out,
    input  wire logic                     spi_miso_out,
    input  wire logic                     spi_sck_out,
    // port 2 pins
    input  wire logic [4:0]               p2_pin_i,
    output      logic [4:0]               p2_pin_o,
    output      logic [4:0]               p2_pin_oe,
    output      logic [4:0]               p2_pullup_en,
    output      logic [4:0]               p2_in
);
    localparam int PW = prp_pkg::P2_WIDTH;

    // synchronisers: top bit is the shared pin, the rest the port 2 pins
    logic [5:0] sync1_q, sync1_d, sync2_q, sync2_d;
    // power-on and reset state
    prp_pkg::prp_pwr_e pwr_q, pwr_d;
    logic [7:0] por_cnt_q, por_cnt_d;
    logic       isp_q, isp_d;
    logic       ext_rst_q, ext_rst_d;
    logic       load_q, load_d;
    // port 2 state
    logic [4:0] latch_q, latch_d;
    logic [9:0] mode_q, mode_d;
    logic       pin_rst_s;
    logic       in_reset;

    always_comb begin
        sync1_d = {rst_pin_i, p2_pin_i};
        sync2_d = sync1_q;
    end

    // released pins read high, so no false reset or edge follows rst_n
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= 6'h3f;
            sync2_q <= 6'h3f;
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
        end
    end

    // pin is a reset while powering up, afterwards only if enabled
    assign pin_rst_s = ~sync2_q[5] & ((pwr_q != prp_pkg::PS_RUN) | user_config_byte_one_rst_en);
    assign in_reset  = ext_rst_q | (pwr_q != prp_pkg::PS_RUN);

    always_comb begin
        pwr_d     = pwr_q;
        por_cnt_d = por_cnt_q;
        isp_d     = isp_q;
        load_d    = 1'b0;
        ext_rst_d = pin_rst_s & (pwr_q == prp_pkg::PS_RUN);
        case (pwr_q)
            prp_pkg::PS_POWER: begin
                if (por_cnt_q == 8'(POR_CYCLES - 1)) begin
                    pwr_d = prp_pkg::PS_SAMPLE;
                end else begin
                    por_cnt_d = por_cnt_q + 8'h01;
                end
            end
            prp_pkg::PS_SAMPLE: begin
                isp_d  = ~sync2_q[5];
                pwr_d  = prp_pkg::PS_RUN;
                load_d = 1'b1;
            end
            prp_pkg::PS_RUN: begin
                if (ext_rst_q & ~pin_rst_s) begin
                    load_d = 1'b1;
                end
            end
            default: pwr_d = prp_pkg::PS_POWER;
        endcase
    end

    // power-on sequence and external reset state
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pwr_q     <= prp_pkg::PS_POWER;
            por_cnt_q <= 8'h00;
            isp_q     <= 1'b0;
            ext_rst_q <= 1'b0;
            load_q    <= 1'b0;
        end else begin
            pwr_q     <= pwr_d;
            por_cnt_q <= por_cnt_d;
            isp_q     <= isp_d;
            ext_rst_q <= ext_rst_d;
            load_q    <= load_d;
        end
    end

    // port latches return to their reset value whenever the chip is in reset
    always_comb begin
        latch_d = latch_q;
        if (in_reset) begin
            latch_d = prp_pkg::P2_LATCH_RESET;
        end else if (p2_latch_wr) begin
            latch_d = p2_latch_wr_data;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            latch_q <= prp_pkg::P2_LATCH_RESET;
        end else begin
            latch_q <= latch_d;
        end
    end

    // modes are forced to input only through reset, software values ignored
    always_comb begin
        mode_d = p2_mode_i;
        if (in_reset) begin
            mode_d = {PW{prp_pkg::MODE_RESET}};
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= {PW{prp_pkg::MODE_RESET}};
        end else begin
            mode_q <= mode_d;
        end
    end

    assign port1_bit5_input           = sync2_q[5];
    assign rst_pin_oe                 = 1'b0;
    assign in_system_programming_mode = isp_q;
    assign periph_rst_n               = ~in_reset;
    assign fetch_addr                 = prp_pkg::RESET_VECTOR;
    assign fetch_addr_load            = load_q;
    assign p2_in                      = sync2_q[4:0];

    // port 2 positions that the spi may take over
    function automatic logic is_spi_pos(input int idx);
        return (idx == prp_pkg::IDX_MOSI) || (idx == prp_pkg::IDX_MISO) || (idx == prp_pkg::IDX_SCK);
    endfunction

    // miso runs against the other two spi pins
    function automatic logic spi_drives(input int idx, input logic master);
        return (idx == prp_pkg::IDX_MISO) ? ~master : master;
    endfunction

    // the clock takes whichever spi position is not a data line
    function automatic logic spi_value(input int idx, input logic mosi, input logic miso, input logic sck);
        logic v;
        v = sck;
        if (idx == prp_pkg::IDX_MOSI) begin
            v = mosi;
        end else if (idx == prp_pkg::IDX_MISO) begin
            v = miso;
        end
        return v;
    endfunction

    // quasi and open-drain only ever pull low; quasi adds the pull-up on a one
    function automatic prp_pkg::prp_pin_s gpio_drive(input logic [1:0] mode, input logic latch);
        prp_pkg::prp_pin_s d;
        d = '{o: 1'b0, oe: 1'b0, pu: 1'b0};
        case (prp_pkg::prp_mode_e'(mode))
            prp_pkg::PM_QUASI: d = '{o: 1'b0, oe: ~latch, pu: latch};
            prp_pkg::PM_PUSH:  d = '{o: latch, oe: 1'b1, pu: 1'b0};
            prp_pkg::PM_INPUT: d = '{o: 1'b0, oe: 1'b0, pu: 1'b0};
            prp_pkg::PM_OPEN:  d = '{o: 1'b0, oe: ~latch, pu: 1'b0};
            default:           d = '{o: 1'b0, oe: 1'b0, pu: 1'b0};
        endcase
        return d;
    endfunction

    // per-pin output drive
    for (genvar i = 0; i < PW; i++) begin : g_pin
        prp_pkg::prp_pin_s pin;
        logic              spi_pin, spi_drive, spi_val;
        always_comb begin
            spi_pin   = spi_en & is_spi_pos(i);
            spi_drive = spi_drives(i, spi_master);
            spi_val   = spi_value(i, spi_mosi_out, spi_miso_out, spi_sck_out);
            pin       = gpio_drive(mode_q[2*i +: 2], latch_q[i]);
            if (in_reset) begin
                pin = '{o: 1'b0, oe: 1'b0, pu: 1'b0};
            end else if (spi_pin) begin
                pin = '{o: spi_val, oe: spi_drive, pu: 1'b0};
            end
        end
        assign p2_pin_o[i]     = pin.o;
        assign p2_pin_oe[i]    = pin.oe;
        assign p2_pullup_en[i] = pin.pu;
    end
endmodule

// *** prp_pkg.sv ***
// package for the port 2 and shared reset pin block
package prp_pkg;
    localparam int P2_WIDTH = 5;
    // positions of port 2 bits inside the 5-bit vector (bit 5 sits at index 4)
    localparam int IDX_BIT0 = 0;
    localparam int IDX_BIT1 = 1;
    localparam int IDX_MOSI = 2;
    localparam int IDX_MISO = 3;
    localparam int IDX_SCK  = 4;
    // first instruction address after reset
    localparam logic [15:0] RESET_VECTOR = 16'h0000;
    // port mode encodings
    typedef enum logic [1:0] {
        PM_QUASI  = 2'b00,
        PM_PUSH   = 2'b01,
        PM_INPUT  = 2'b10,
        PM_OPEN   = 2'b11
    } prp_mode_e;
    localparam logic [1:0] MODE_RESET = 2'b10;
    localparam logic [4:0] P2_LATCH_RESET = 5'h1f;
    // power-on sequence states
    typedef enum logic [1:0] {
        PS_POWER = 2'b00,
        PS_SAMPLE = 2'b01,
        PS_RUN   = 2'b10
    } prp_pwr_e;
    // one port 2 pin as three signals
    typedef struct packed {
        logic o;
        logic oe;
        logic pu;
    } prp_pin_s;
endpackage

// *** prp_port2_reset_checker.sv ***
// assertion checker for the port 2 and shared reset pin block
`timescale 1ns/1ps
module prp_port2_reset_checker (
    input wire logic       sys_clk,
    input wire logic       rst_n,
    input wire logic       user_config_byte_one_rst_en,
    input wire logic       port1_bit5_input,
    input wire logic       rst_pin_oe,
    input wire logic       periph_rst_n,
    input wire logic       fetch_addr_load,
    input wire logic       spi_en,
    input wire logic       spi_master,
    input wire logic [4:0] p2_pin_oe,
    input wire logic [4:0] p2_pullup_en
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    property p_hiz; !rst_pin_oe; endproperty
    a_hiz: assert property (p_hiz) else $error("shared pin driven");
    property p_run; fetch_addr_load |-> periph_rst_n; endproperty
    a_run: assert property (p_run) else $error("fetch while in reset");
    property p_pulse; fetch_addr_load |=> !fetch_addr_load; endproperty
    a_pulse: assert property (p_pulse) else $error("fetch load too long");
    property p_mosi; spi_en && periph_rst_n |-> p2_pin_oe[2] == spi_master; endproperty
    a_mosi: assert property (p_mosi) else $error("mosi direction");
    property p_miso; spi_en && periph_rst_n |-> p2_pin_oe[3] != spi_master; endproperty
    a_miso: assert property (p_miso) else $error("miso direction");
    property p_sck; spi_en && periph_rst_n |-> p2_pin_oe[4] == spi_master; endproperty
    a_sck: assert property (p_sck) else $error("clock direction");
    property p_ext; user_config_byte_one_rst_en && $fell(port1_bit5_input) |=> !periph_rst_n; endproperty
    a_ext: assert property (p_ext) else $error("pin low ignored");
    property p_cfg; !user_config_byte_one_rst_en && periph_rst_n |=> periph_rst_n; endproperty
    a_cfg: assert property (p_cfg) else $error("reset while unselected");
    property p_rst_pins; !periph_rst_n |-> p2_pin_oe == 5'h00 && p2_pullup_en == 5'h00; endproperty
    a_rst_pins: assert property (p_rst_pins) else $error("port 2 active in reset");
    c_ext: cover property (user_config_byte_one_rst_en && !periph_rst_n);
    c_master: cover property (spi_en && spi_master);
    c_slave: cover property (spi_en && !spi_master);
    c_load: cover property (fetch_addr_load);
endmodule
bind prp_port2_reset prp_port2_reset_checker i_prp_port2_reset_checker (.*);

// *** prp_pin_peer.sv ***
// board and spi peer model for the shared reset pin and port 2
`timescale 1ns/1ps
module prp_pin_peer (
    input  wire logic       ext_rst_n,
    input  wire logic [4:0] peer_val,
    input  wire logic [4:0] p2_pin_o,
    input  wire logic [4:0] p2_pin_oe,
    output      logic       rst_pin_i,
    output      logic [4:0] p2_pin_i
);
    assign rst_pin_i = ext_rst_n;
    assign p2_pin_i = (p2_pin_oe & p2_pin_o) | (~p2_pin_oe & peer_val);
endmodule

// *** prp_port2_reset_tb_top.sv ***
// self-checking testbench for the port 2 and shared reset pin block
`timescale 1ns/1ps
module prp_port2_reset_tb_top;
    logic        sys_clk = 1'b0, rst_n = 1'b0, ext_rst_n = 1'b0, spi_en = 1'b0, spi_master = 1'b0;
    logic        user_config_byte_one_rst_en = 1'b0, p2_latch_wr = 1'b1;
    logic        spi_mosi_out = 1'b1, spi_miso_out = 1'b1, spi_sck_out = 1'b1;
    logic [9:0]  p2_mode_i = 10'h155;
    logic [4:0]  p2_latch_wr_data = 5'h1f, peer_val = 5'h0a, p2_pin_i, p2_pin_o, p2_pin_oe, p2_pullup_en, p2_in;
    logic        rst_pin_i, port1_bit5_input, rst_pin_oe, in_system_programming_mode, periph_rst_n, fetch_addr_load;
    logic [15:0] fetch_addr;
    int          num_errors = 0, total_checks = 0;
    always #25 sys_clk = ~sys_clk;
    prp_port2_reset #(
        .POR_CYCLES(2)
    ) i_prp_port2_reset (
        .sys_clk                     (sys_clk),
        .rst_n                       (rst_n),
        .rst_pin_i                   (rst_pin_i),
        .user_config_byte_one_rst_en (user_config_byte_one_rst_en),
        .port1_bit5_input            (port1_bit5_input),
        .rst_pin_oe                  (rst_pin_oe),
        .in_system_programming_mode  (in_system_programming_mode),
        .periph_rst_n                (periph_rst_n),
        .fetch_addr                  (fetch_addr),
        .fetch_addr_load             (fetch_addr_load),
        .p2_mode_i                   (p2_mode_i),
        .p2_latch_wr_data            (p2_latch_wr_data),
        .p2_latch_wr                 (p2_latch_wr),
        .spi_en                      (spi_en),
        .spi_master                  (spi_master),
        .spi_mosi_out                (spi_mosi_out),
        .spi_miso_out                (spi_miso_out),
        .spi_sck_out                 (spi_sck_out),
        .p2_pin_i                    (p2_pin_i),
        .p2_pin_o                    (p2_pin_o),
        .p2_pin_oe                   (p2_pin_oe),
        .p2_pullup_en                (p2_pullup_en),
        .p2_in                       (p2_in)
    );
    prp_pin_peer i_prp_pin_peer (
        .ext_rst_n (ext_rst_n),
        .peer_val  (peer_val),
        .p2_pin_o  (p2_pin_o),
        .p2_pin_oe (p2_pin_oe),
        .rst_pin_i (rst_pin_i),
        .p2_pin_i  (p2_pin_i)
    );
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk) #5;
    endtask
    task automatic cmp(input logic [16:0] got, input logic [16:0] exp);
        total_checks++;
        num_errors += int'(got !== exp);
        if (got !== exp) $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // pin held low across power-on, then past it with the reset function unselected
    task automatic t_power();
        step(6);
        cmp({p2_pin_oe, p2_pullup_en, periph_rst_n}, 17'h0_0000);
        rst_n = 1'b1;
        step(12);
        cmp({in_system_programming_mode, periph_rst_n, port1_bit5_input, rst_pin_oe}, 17'h0_000c);
        ext_rst_n = 1'b1;
    endtask
    // pins 0 and 1 as plain bits in different modes, pins 2 to 5 handed to the spi
    task automatic t_port();
        p2_mode_i = 10'h199;
        spi_en = 1'b1;
        step(1);
        cmp({p2_pin_oe, p2_pin_o & p2_pin_oe}, 17'h0_0129);
        spi_master   = 1'b1;
        spi_mosi_out = 1'b0;
        step(2);
        cmp({p2_pin_oe, p2_pin_o & p2_pin_oe}, 17'h0_02b1);
    endtask
    // plain bits in quasi, open-drain, input and push-pull with new latch data, then the synced pin levels
    task automatic t_modes();
        spi_en           = 1'b0;
        p2_mode_i        = 10'h06c;
        p2_latch_wr_data = 5'h16;
        step(1);
        cmp({p2_pin_oe, p2_pullup_en, p2_pin_o}, 17'h0_2600);
        step(1);
        cmp(p2_in, 17'h0_001f);
        step(1);
        cmp(p2_in, 17'h0_0002);
    endtask
    // pin reset with latch writes held off: latches must come back at their reset value
    task automatic t_ext();
        user_config_byte_one_rst_en = 1'b1;
        p2_latch_wr = 1'b0;
        ext_rst_n = 1'b0;
        step(2);
        cmp(periph_rst_n, 17'h0_0001);
        step(2);
        cmp({periph_rst_n, p2_pullup_en, p2_pin_oe}, 17'h0_0000);
        ext_rst_n = 1'b1;
        repeat (40) if (fetch_addr_load !== 1'b1) step(1);
        cmp({fetch_addr_load, fetch_addr}, 17'h1_0000);
        step(1);
        cmp({p2_pin_oe, p2_pullup_en, p2_pin_o}, 17'h0_2228);
    endtask
    // system reset in mid-run with the shared pin high: no programming mode, start after the power-on count
    task automatic t_again();
        rst_n = 1'b0;
        step(2);
        cmp({periph_rst_n, in_system_programming_mode, p2_pin_oe, port1_bit5_input}, 17'h0_0001);
        rst_n = 1'b1;
        step(2);
        cmp({fetch_addr_load, periph_rst_n}, 17'h0_0000);
        step(1);
        cmp({fetch_addr_load, in_system_programming_mode, periph_rst_n}, 17'h0_0005);
        step(1);
        cmp({fetch_addr_load, periph_rst_n}, 17'h0_0001);
    endtask
    initial begin
        t_power();
        t_port();
        t_modes();
        t_ext();
        t_again();
        give_verdict();
    end
    initial begin
        #200000 num_errors++;
        give_verdict();
    end
endmodule
